// ### design/pbf_pkg.sv
// pbf_pkg: constants, pin-function kinds and state type for the port b
// pin function select block. assumes a 16-pin port, 16-bit registers.
//
// Contract
// - direction bit n governs port pin n, bits fifteen down to zero.
// - port, timer capture/compare, serial clock: direction 1 output, 0 input.
// - direction bit ignored for every other selected function.
// - direction register is 16 bits, readable and writable.
// - direction clears on power-on reset only, kept otherwise.
// - both function-select registers clear on power-on reset only.
// - high register serves pins 15..8, low register 7..0, two bits each.
// - pin 15: port, interrupt 7, reserved, pattern 15.
// - pin 14: port, interrupt 6, reserved, pattern 14.
// - pin 13: port, interrupt 5, serial 1 clock, pattern 13.
// - pin 12: port, interrupt 4, serial 0 clock, pattern 12.
// - pin 11: port, reserved, serial 1 transmit, pattern 11.
// - pin 10: port, reserved, serial 1 receive, pattern 10.
// - pin 9: port, reserved, serial 0 transmit, pattern 9.
// - pin 8: port, reserved, serial 0 receive, pattern 8.
// - low register: code 00 port, code 11 matching pattern output.
`default_nettype none

package pbf_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [1:0]  ADDR_DIR  = 2'h0;
    localparam logic [1:0]  ADDR_FHI  = 2'h1;
    localparam logic [1:0]  ADDR_FLO  = 2'h2;
    localparam logic [1:0]  ADDR_DATA = 2'h3;
    localparam logic [15:0] RST_DIR   = 16'h0000;
    localparam logic [15:0] RST_FSEL  = 16'h0000;
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [15:0] RD_NONE   = 16'h0000;

    // ----------------------------------------------------------------
    // field layout and codes
    // ----------------------------------------------------------------
    localparam int          NUM_PINS   = 16;
    localparam int          HALF_PINS  = 8;
    localparam int          FIELD_W    = 2;
    localparam logic [1:0]  FN_PORT    = 2'h0;
    localparam logic [1:0]  FN_ALT1    = 2'h1;
    localparam logic [1:0]  FN_ALT2    = 2'h2;
    localparam logic [1:0]  FN_PATTERN = 2'h3;
    localparam logic        IDLE_HIGH  = 1'b1;
    localparam logic        IDLE_LOW   = 1'b0;

    typedef enum logic [3:0] {
        KIND_PORT, KIND_IRQ, KIND_PATTERN, KIND_TX, KIND_RX,
        KIND_SCK, KIND_TCC, KIND_TOUT, KIND_TCLK, KIND_NONE
    } pbf_kind_t;

    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] fhi;
        logic [15:0] flo;
        logic [15:0] data;
        logic [15:0] rdData;
        logic [15:0] padOut;
        logic [15:0] padOe;
        logic [3:0]  irq;
        logic [1:0]  rx;
        logic [1:0]  sckIn;
        logic [5:0]  tcc;
        logic [1:0]  tclk;
    } pbf_state_t;

    // function of a pin for a given two-bit code
    function automatic pbf_kind_t pbf_pin_kind(input int pin, input logic [1:0] code);
        pbf_kind_t k;
        k = KIND_NONE;
        case (code)
            FN_PORT:    k = KIND_PORT;
            FN_PATTERN: k = KIND_PATTERN;
            FN_ALT1:
            begin
                if (pin >= 12)
                    k = KIND_IRQ;
                else if (pin == 6 || pin == 7)
                    k = KIND_TCLK;
            end
            FN_ALT2:
            begin
                if (pin <= 5)
                    k = KIND_TCC;
                else if (pin <= 7)
                    k = KIND_TOUT;
                else if (pin == 8 || pin == 10)
                    k = KIND_RX;
                else if (pin == 9 || pin == 11)
                    k = KIND_TX;
                else if (pin == 12 || pin == 13)
                    k = KIND_SCK;
            end
            default:    k = KIND_NONE;
        endcase
        return k;
    endfunction : pbf_pin_kind

endpackage : pbf_pkg

`default_nettype wire

// ### design/pbf_pin_cell.sv
// pbf_pin_cell: per-pin drive decision from the selected function.
// assumes kind is already decoded; purely combinational.
`timescale 1ns/100ps
`default_nettype none

module pbf_pin_cell
    import pbf_pkg::*;
(
    input  wire pbf_kind_t kind,        // selected pin function
    input  wire logic      dirBit,      // direction bit, 1 = output
    input  wire logic      portBit,     // port output latch
    input  wire logic      patternBit,  // pattern generator output
    input  wire logic      altOut,      // peripheral output for this pin
    output logic           padOe,       // drive enable
    output logic           padOut,      // drive level
    output logic           feedIn       // pad routed to a peripheral
);

    always_comb
    begin
        padOe  = 1'b0;
        padOut = 1'b0;
        feedIn = 1'b0;
        case (kind)
            KIND_PORT:
            begin
                padOe  = dirBit;
                padOut = dirBit & portBit;
            end
            KIND_TCC, KIND_SCK:
            begin
                padOe  = dirBit;
                padOut = dirBit & altOut;
                feedIn = ~dirBit;
            end
            KIND_PATTERN:
            begin
                padOe  = 1'b1;
                padOut = patternBit;
            end
            KIND_TX, KIND_TOUT:
            begin
                padOe  = 1'b1;
                padOut = altOut;
            end
            KIND_IRQ, KIND_RX, KIND_TCLK:
                feedIn = 1'b1;
            // reserved code: input, nothing connected
            default:
                feedIn = 1'b0;
        endcase
    end

endmodule : pbf_pin_cell

`default_nettype wire

// ### design/pbf_port_b_select.sv
// pbf_port_b_select: port b direction, function select and data registers
// plus pad muxing. assumes pads resolved outside from padOe/padOut, and
// all inputs synchronous to sys_clk; rst_b stands for power-on reset.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module pbf_port_b_select
    import pbf_pkg::*;
(
    input  wire logic        sys_clk,           // 100 MHz clock
    input  wire logic        rst_b,             // power-on reset, active low
    input  wire logic [1:0]  regAddr,           // register index
    input  wire logic [15:0] regWdata,          // write data
    input  wire logic        regWr,             // write strobe
    input  wire logic        regRd,             // read strobe
    output logic      [15:0] regRdata,          // read data, cycle after strobe
    input  wire logic [15:0] padIn,             // pad levels
    output logic      [15:0] padOut,            // pad drive levels
    output logic      [15:0] padOe,             // pad drive enables
    input  wire logic [15:0] patternOutSrc,     // pattern generator bits
    input  wire logic [1:0]  serialTransmitOut, // serial transmit data
    input  wire logic [1:0]  serialClockOut,    // serial clock out
    input  wire logic [5:0]  timerCcOut,        // timer compare out, pins 5..0
    input  wire logic [1:0]  timerCmpOut,       // timer compare out, pins 7..6
    output logic      [3:0]  extInterruptIn,    // interrupt inputs 7..4
    output logic      [1:0]  serialReceiveIn,   // serial receive data
    output logic      [1:0]  serialClockIn,     // serial clock in
    output logic      [5:0]  timerCcIn,         // timer capture in, pins 5..0
    output logic      [1:0]  timerClockIn       // timer clock in, pins 7..6
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam pbf_state_t ST_RESET = '{
        dir:    RST_DIR,
        fhi:    RST_FSEL,
        flo:    RST_FSEL,
        data:   RST_DATA,
        rdData: RD_NONE,
        padOut: 16'h0000,
        padOe:  16'h0000,
        irq:    4'hf,
        rx:     2'h3,
        sckIn:  2'h3,
        tcc:    6'h00,
        tclk:   2'h0
    };

    pbf_state_t  st;
    pbf_state_t  next_st;
    pbf_kind_t   kind [NUM_PINS];
    logic [15:0] cellOe;
    logic [15:0] cellOut;
    logic [15:0] feedIn;
    logic [15:0] altOut;

    assign altOut = {2'b00, serialClockOut, serialTransmitOut[1], 1'b0,
                     serialTransmitOut[0], 1'b0, timerCmpOut, timerCcOut};

    // ----------------------------------------------------------------
    // per-pin decode
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_pin
            if (gi >= HALF_PINS)
            begin : g_hi
                assign kind[gi] = pbf_pin_kind(gi, st.fhi[FIELD_W*(gi-HALF_PINS) +: FIELD_W]);
            end
            else
            begin : g_lo
                assign kind[gi] = pbf_pin_kind(gi, st.flo[FIELD_W*gi +: FIELD_W]);
            end

            pbf_pin_cell u_cell (
                .kind       (kind[gi]),
                .dirBit     (st.dir[gi]),
                .portBit    (st.data[gi]),
                .patternBit (patternOutSrc[gi]),
                .altOut     (altOut[gi]),
                .padOe      (cellOe[gi]),
                .padOut     (cellOut[gi]),
                .feedIn     (feedIn[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st        = st;
        next_st.rdData = RD_NONE;
        // only power-on reset clears these; otherwise only a register write changes them
        if (regWr)
        begin
            case (regAddr)
                ADDR_DIR:  next_st.dir  = regWdata;
                ADDR_FHI:  next_st.fhi  = regWdata;
                ADDR_FLO:  next_st.flo  = regWdata;
                ADDR_DATA: next_st.data = regWdata;
                default:   next_st.data = st.data;
            endcase
        end
        if (regRd)
        begin
            case (regAddr)
                ADDR_DIR:  next_st.rdData = st.dir;
                ADDR_FHI:  next_st.rdData = st.fhi;
                ADDR_FLO:  next_st.rdData = st.flo;
                // output pins echo the latch, others the pad
                ADDR_DATA: next_st.rdData = (st.dir & st.data) | (~st.dir & padIn);
                default:   next_st.rdData = RD_NONE;
            endcase
        end
        next_st.padOe  = cellOe;
        next_st.padOut = cellOut;
        // interrupts 7..4 on pins 15..12
        for (int k = 0; k < 4; k++)
        begin
            next_st.irq[k] = (kind[12+k] == KIND_IRQ) ? padIn[12+k] : IDLE_HIGH;
        end
        // serial clocks on pins 13/12, receive on pins 10/8
        for (int k = 0; k < 2; k++)
        begin
            next_st.sckIn[k] = (kind[12+k] == KIND_SCK && feedIn[12+k]) ?
                               padIn[12+k] : IDLE_HIGH;
            next_st.rx[k]    = (kind[8+2*k] == KIND_RX) ? padIn[8+2*k] : IDLE_HIGH;
            next_st.tclk[k]  = (kind[6+k] == KIND_TCLK) ? padIn[6+k] : IDLE_LOW;
        end
        for (int k = 0; k < 6; k++)
        begin
            next_st.tcc[k] = (kind[k] == KIND_TCC && feedIn[k]) ? padIn[k] : IDLE_LOW;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign regRdata        = st.rdData;
    assign padOut          = st.padOut;
    assign padOe           = st.padOe;
    assign extInterruptIn  = st.irq;
    assign serialReceiveIn = st.rx;
    assign serialClockIn   = st.sckIn;
    assign timerCcIn       = st.tcc;
    assign timerClockIn    = st.tclk;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_dir_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (regWr && regAddr == ADDR_DIR) |=> (st.dir == $past(regWdata));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction register did not take written value");

    property p_dir_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !(regWr && regAddr == ADDR_DIR) |=> $stable(st.dir);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction register changed without a write");

    property p_fsel_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        !(regWr && (regAddr == ADDR_FHI || regAddr == ADDR_FLO)) |=>
            $stable(st.fhi) && $stable(st.flo);
    endproperty
    a_fsel_hold: assert property (p_fsel_hold)
        else $error("function select changed without a write");

    property p_read_fhi;
        @(posedge sys_clk) disable iff (!rst_b)
        (regRd && regAddr == ADDR_FHI) |=> (regRdata == $past(st.fhi)) ##1
            (regRdata == RD_NONE || $past(regRd));
    endproperty
    a_read_fhi: assert property (p_read_fhi)
        else $error("high function select read back wrong");

    generate
        for (gi = 0; gi < NUM_PINS; gi++)
        begin : g_chk
            property p_dir_governs;
                @(posedge sys_clk) disable iff (!rst_b)
                (kind[gi] == KIND_PORT || kind[gi] == KIND_TCC || kind[gi] == KIND_SCK)
                    |=> (padOe[gi] == $past(st.dir[gi]));
            endproperty
            a_dir_governs: assert property (p_dir_governs)
                else $error("pad enable does not follow direction bit");

            property p_fixed_dir;
                @(posedge sys_clk) disable iff (!rst_b)
                (kind[gi] != KIND_PORT && kind[gi] != KIND_TCC && kind[gi] != KIND_SCK)
                    |=> (padOe[gi] == ($past(kind[gi]) == KIND_PATTERN ||
                                       $past(kind[gi]) == KIND_TX ||
                                       $past(kind[gi]) == KIND_TOUT));
            endproperty
            a_fixed_dir: assert property (p_fixed_dir)
                else $error("fixed function pad enable wrong");
        end
    endgenerate

    property p_ext_interrupt_in_7;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[15:14] == FN_ALT1) |=> (extInterruptIn[3] == $past(padIn[15]));
    endproperty
    a_ext_interrupt_in_7: assert property (p_ext_interrupt_in_7)
        else $error("pin 15 interrupt input not routed");

    property p_serial1_clock_io;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[11:10] == FN_ALT2 && !st.dir[13]) |=> (serialClockIn[1] == $past(padIn[13]));
    endproperty
    a_serial1_clock_io: assert property (p_serial1_clock_io)
        else $error("pin 13 serial clock input not routed");

    property p_tx1;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[7:6] == FN_ALT2) |=> padOe[11] && (padOut[11] == $past(serialTransmitOut[1]));
    endproperty
    a_tx1: assert property (p_tx1)
        else $error("pin 11 transmit output not driven");

    property p_reserved11;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[7:6] == FN_ALT1) |=> !padOe[11];
    endproperty
    a_reserved11: assert property (p_reserved11)
        else $error("reserved code drives pin 11");

    property p_pattern0;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.flo[1:0] == FN_PATTERN) |=> padOe[0] && (padOut[0] == $past(patternOutSrc[0]));
    endproperty
    a_pattern0: assert property (p_pattern0)
        else $error("pin 0 pattern output not driven");

    property p_fhi_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (regWr && regAddr == ADDR_FHI) |=> (st.fhi == $past(regWdata));
    endproperty
    a_fhi_write: assert property (p_fhi_write)
        else $error("high function select did not take written value");

    property p_flo_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (regWr && regAddr == ADDR_FLO) |=> (st.flo == $past(regWdata));
    endproperty
    a_flo_write: assert property (p_flo_write)
        else $error("low function select did not take written value");

    property p_read_dir;
        @(posedge sys_clk) disable iff (!rst_b)
        (regRd && regAddr == ADDR_DIR) |=> (regRdata == $past(st.dir));
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("direction register read back wrong");

    property p_ext_interrupt_in_6;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[13:12] == FN_ALT1) |=> (extInterruptIn[2] == $past(padIn[14]));
    endproperty
    a_ext_interrupt_in_6: assert property (p_ext_interrupt_in_6)
        else $error("pin 14 interrupt input not routed");

    property p_reserved15;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[15:14] == FN_ALT2) |=> !padOe[15] && extInterruptIn[3];
    endproperty
    a_reserved15: assert property (p_reserved15)
        else $error("reserved code on pin 15 drives or feeds");

    property p_serial0_clock_io;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[9:8] == FN_ALT2 && !st.dir[12]) |=> (serialClockIn[0] == $past(padIn[12]));
    endproperty
    a_serial0_clock_io: assert property (p_serial0_clock_io)
        else $error("pin 12 serial clock input not routed");

    property p_rx1;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[5:4] == FN_ALT2) |=> !padOe[10] && (serialReceiveIn[1] == $past(padIn[10]));
    endproperty
    a_rx1: assert property (p_rx1)
        else $error("pin 10 receive input not routed");

    property p_tx0;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[3:2] == FN_ALT2) |=> padOe[9] && (padOut[9] == $past(serialTransmitOut[0]));
    endproperty
    a_tx0: assert property (p_tx0)
        else $error("pin 9 transmit output not driven");

    property p_rx0;
        @(posedge sys_clk) disable iff (!rst_b)
        (st.fhi[1:0] == FN_ALT2) |=> !padOe[8] && (serialReceiveIn[0] == $past(padIn[8]));
    endproperty
    a_rx0: assert property (p_rx0)
        else $error("pin 8 receive input not routed");

endmodule : pbf_port_b_select

`default_nettype wire

// ### bench/pbf_board_model.sv
// pbf_board_model: board side of the sixteen port b pads.
// assumes pad enable and pad level come registered from the port block.
`timescale 1ns/100ps
`default_nettype none

module pbf_board_model
(
    input  wire logic [15:0] padOut,     // level driven by the port
    input  wire logic [15:0] padOe,      // port drive enable
    input  wire logic [15:0] boardLevel, // level the board drives
    output logic      [15:0] padIn       // resolved pad level
);
    // board drives through series resistors, so an enabled port wins;
    // an undriven pad shows the board level, never a stale port value
    assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule : pbf_board_model

`default_nettype wire

// ### bench/tb_pbf_port_b_select.sv
// tb_pbf_port_b_select: register-level bench for the port b pin function select.
// assumes pbf_board_model closes the pad loop; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_pbf_port_b_select
    import pbf_pkg::*;
();
    logic        sys_clk;
    logic        rst_b;
    logic [1:0]  regAddr;
    logic [15:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [15:0] regRdata;
    logic [15:0] padIn;
    logic [15:0] padOut;
    logic [15:0] padOe;
    logic [15:0] patternOutSrc;
    logic [1:0]  serialTransmitOut;
    logic [1:0]  serialClockOut;
    logic [5:0]  timerCcOut;
    logic [1:0]  timerCmpOut;
    logic [3:0]  extInterruptIn;
    logic [1:0]  serialReceiveIn;
    logic [1:0]  serialClockIn;
    logic [5:0]  timerCcIn;
    logic [1:0]  timerClockIn;
    logic [15:0] boardLevel;
    logic [15:0] perIn;
    int          fails;
    int          cmpCount;

    // all peripheral inputs in one word: irq, rx, sck, capture, timer clock
    assign perIn = {extInterruptIn, serialReceiveIn, serialClockIn, timerCcIn, timerClockIn};

    pbf_port_b_select dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .patternOutSrc(patternOutSrc),
        .serialTransmitOut(serialTransmitOut), .serialClockOut(serialClockOut),
        .timerCcOut(timerCcOut), .timerCmpOut(timerCmpOut),
        .extInterruptIn(extInterruptIn), .serialReceiveIn(serialReceiveIn),
        .serialClockIn(serialClockIn), .timerCcIn(timerCcIn), .timerClockIn(timerClockIn)
    );

    pbf_board_model board_u (
        .padOut(padOut), .padOe(padOe), .boardLevel(boardLevel), .padIn(padIn)
    );

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask : rd

    // pads and peripheral inputs lag a register write by two edges
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic cfg(input logic [15:0] d, input logic [15:0] h, input logic [15:0] l);
        wr(ADDR_DIR, d);
        wr(ADDR_FHI, h);
        wr(ADDR_FLO, l);
        settle();
    endtask : cfg

    task automatic pins(input logic [15:0] oe, input logic [15:0] out, input logic [15:0] per);
        chk(padOe, oe);
        chk(padOut, out);
        chk(perIn, per);
    endtask : pins

    task automatic powerOn();
        rst_b <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle();
    endtask : powerOn

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        complete_run();
    end

    initial
    begin
        fails             = 0;
        cmpCount          = 0;
        rst_b             = 1'b0;
        regAddr           = ADDR_DIR;
        regWdata          = 16'h0000;
        regWr             = 1'b0;
        regRd             = 1'b0;
        patternOutSrc     = 16'h3c96;
        serialTransmitOut = 2'h2;
        serialClockOut    = 2'h1;
        timerCcOut        = 6'h2d;
        timerCmpOut       = 2'h2;
        boardLevel        = 16'hab65;
        powerOn();
        pins(16'h0000, 16'h0000, 16'hff00);
        for (int i = 0; i < 3; i++)
            rd(2'(i), 16'h0000);
        for (int i = 0; i < 3; i++)
            wr(2'(i), 16'ha5c3 ^ 16'(i));
        for (int i = 0; i < 3; i++)
            rd(2'(i), 16'ha5c3 ^ 16'(i));
        @(posedge sys_clk);
        #1;
        chk(regRdata, 16'h0000);
        // plain port: direction bit per pin
        cfg(16'h00ff, 16'h0000, 16'h0000);
        wr(ADDR_DATA, 16'h1234);
        settle();
        pins(16'h00ff, 16'h0034, 16'hff00);
        rd(ADDR_DATA, 16'hab34);
        cfg(16'h8421, 16'h0000, 16'h0000);
        pins(16'h8421, 16'h0020, 16'hff00);
        // pattern output everywhere, direction ignored
        cfg(16'h0000, 16'hffff, 16'hffff);
        pins(16'hffff, 16'h3c96, 16'hff00);
        @(posedge sys_clk);
        patternOutSrc <= 16'h69c3;
        cfg(16'hffff, 16'hffff, 16'hffff);
        pins(16'hffff, 16'h69c3, 16'hff00);
        // interrupts on 15..12, reserved code on 11..8
        cfg(16'hffff, 16'h5555, 16'h0000);
        pins(16'h00ff, 16'h0034, 16'haf00);
        @(posedge sys_clk);
        boardLevel <= 16'h5b65;
        settle();
        chk(perIn, 16'h5f00);
        // serial functions, clock pins follow direction
        cfg(16'h0000, 16'haaaa, 16'h0000);
        pins(16'h0a00, 16'h0800, 16'hf500);
        cfg(16'hffff, 16'haaaa, 16'h0000);
        pins(16'h3aff, 16'h1834, 16'hf700);
        // timer functions on the low half
        cfg(16'h0000, 16'h0000, 16'haaaa);
        pins(16'h00c0, 16'h0080, 16'hff94);
        cfg(16'hffff, 16'h0000, 16'haaaa);
        pins(16'hffff, 16'h12ad, 16'hff00);
        cfg(16'hffff, 16'h0000, 16'h5555);
        pins(16'hff00, 16'h1200, 16'hff01);
        // second power-on reset clears every select register
        powerOn();
        pins(16'h0000, 16'h0000, 16'hff00);
        for (int i = 0; i < 3; i++)
            rd(2'(i), 16'h0000);
        complete_run();
    end
endmodule : tb_pbf_port_b_select

`default_nettype wire
